// ===== rtl/fcc_carriage.v
// Forms control buffer, carriage address and command engine of the line printer control.
`timescale 1ns/1ps
// Functional notes
// - Forms buffer has 180 line entries.
// - Entry holds channel code 1 to 12.
// - Carriage address tracks line, advances on motion.
// - Skip advances until entry holds requested channel.
// - Absent channel stops after line 1 seen twice.
// - End flag marks last line of short form.
// - First entry flag selects six or eight lpi.
// - Load command stores host supplied forms codes.
// - Load flags error on missing end or bad code.
// - Indexing byte shifts print line 0 to 30.
// - Indexing byte written by same load command.
// - Six sense bytes report malfunctions.
// - Retryable fault recorded, carriage motion suppressed.
// - Line has 132 or optional 150 positions.
`include "fcc_regs.vh"
module fcc_carriage #(
  parameter LINES = 180,
  parameter ADDR_W = 8,
  parameter WIDE_LINE = 0
) (
  // Clock, enable and reset.
  input wire core_clk,
  input wire clk_en,
  input wire reset_n,
  // Avalon-MM slave.
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // Printer side.
  input wire print_parity_err,
  output reg form_step,
  output wire lpi8_mode,
  output wire [7:0] print_offset,
  output wire [7:0] line_positions,
  output wire irq
);
// ****************************************************************
// Storage and state
// ****************************************************************
  localparam ST_IDLE = 2'h0;
  localparam ST_MOVE = 2'h1;
  localparam ST_LOAD = 2'h2;
  reg [5:0] fcb_mem [0:LINES-1];
  reg [1:0] state_q;
  reg [ADDR_W-1:0] carr_q;
  reg [ADDR_W-1:0] ld_ptr_q;
  reg [ADDR_W-1:0] remain_q;
  reg [3:0] want_ch_q;
  reg skip_q;
  reg [1:0] line1_seen_q;
  reg ld_end_seen_q;
  reg ld_bad_q;
  reg [7:0] index_q;
  reg lpi8_q;
  reg motion_hold_q;
  reg [`FCC_EV_W-1:0] irq_stat_q;
  reg [`FCC_EV_W-1:0] irq_mask_q;
  reg [47:0] sense_q;
  reg ack_q;
  reg [31:0] rd_mux;
  reg [`FCC_EV_W-1:0] ev_set;
  wire [5:0] cur_ent;
  wire [ADDR_W-1:0] next_addr;
  wire acc;
  wire wr_cmd;
  wire wr_data;
  wire [1:0] cmd_op;
  wire [7:0] cmd_arg;
  wire wr_ok;
  wire wr_ctrl;
  wire wr_stat;
  wire wr_mask;
  wire ld_room;
  wire [`FCC_EV_W-1:0] irq_clr;
// ****************************************************************
// Functions
// ****************************************************************
  // Wraps to line 1 after the flagged last line or after the last buffer entry.
  function [ADDR_W-1:0] fcc_next;
    input [ADDR_W-1:0] a;
    input end_flag;
    begin
      if (end_flag || a == LINES - 1) begin
        fcc_next = {ADDR_W{1'b0}};
      end else begin
        fcc_next = a + 1'b1;
      end
    end
  endfunction
  function fcc_ch_ok;
    input [3:0] ch;
    begin
      fcc_ch_ok = (ch <= `FCC_CH_MAX);
    end
  endfunction
  // Register write strobe for one word address, taken only in the acknowledge cycle.
  function fcc_wr_hit;
    input ok;
    input [3:0] addr;
    input [3:0] target;
    begin
      fcc_wr_hit = ok && (addr == target);
    end
  endfunction
  // Hardware set wins over a write-one clear in the same cycle.
  function [`FCC_EV_W-1:0] fcc_w1c;
    input [`FCC_EV_W-1:0] cur;
    input [`FCC_EV_W-1:0] clr;
    input [`FCC_EV_W-1:0] set;
    begin
      fcc_w1c = (cur & ~clr) | set;
    end
  endfunction
// ****************************************************************
// Bus decode and outputs
// ****************************************************************
  assign cur_ent = fcb_mem[carr_q];
  assign next_addr = fcc_next(carr_q, cur_ent[`FCC_ENT_END_BIT]);
  // One wait cycle per access, so read data always come from a flip-flop.
  assign acc = (avs_read || avs_write) && !ack_q;
  // A low enable keeps the master waiting, so no write is answered in a frozen cycle.
  assign avs_waitrequest = (avs_read || avs_write) && !(ack_q && clk_en);
  assign wr_ok = avs_write && ack_q && clk_en;
  assign wr_cmd = fcc_wr_hit(wr_ok, avs_address, `FCC_A_CMD);
  assign wr_data = fcc_wr_hit(wr_ok, avs_address, `FCC_A_LOAD_DATA);
  assign wr_ctrl = fcc_wr_hit(wr_ok, avs_address, `FCC_A_CTRL);
  assign wr_stat = fcc_wr_hit(wr_ok, avs_address, `FCC_A_IRQ_STAT);
  assign wr_mask = fcc_wr_hit(wr_ok, avs_address, `FCC_A_IRQ_MASK);
  assign ld_room = (ld_ptr_q <= LINES);
  assign irq_clr = wr_stat ? avs_writedata[`FCC_EV_W-1:0] : {`FCC_EV_W{1'b0}};
  assign cmd_op = avs_writedata[`FCC_CMD_OP_MSB:`FCC_CMD_OP_LSB];
  assign cmd_arg = avs_writedata[`FCC_CMD_ARG_MSB:`FCC_CMD_ARG_LSB];
  assign lpi8_mode = lpi8_q;
  assign print_offset = index_q;
  // Print speed does not depend on the line width; only the count of positions changes.
  assign line_positions = (WIDE_LINE != 0) ? `FCC_POS_WIDE : `FCC_POS_STD;
  assign irq = |(irq_stat_q & irq_mask_q);
// ****************************************************************
// Buffer write port
// ****************************************************************
  always @(posedge core_clk) begin
    if (clk_en && state_q == ST_LOAD && wr_data && ld_room && ld_ptr_q != 0) begin
      fcb_mem[ld_ptr_q - 1'b1] <= avs_writedata[5:0];
    end
  end
// ****************************************************************
// Register bus
// ****************************************************************
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
      avs_readdata <= 32'h0;
    end else if (clk_en) begin
      ack_q <= acc;
      if (acc && avs_read) begin
        avs_readdata <= rd_mux;
      end
    end
  end
  always @* begin
    case (avs_address)
      `FCC_A_CTRL: rd_mux = {31'h0, motion_hold_q};
      `FCC_A_STATUS: rd_mux = {28'h0, lpi8_q, skip_q, state_q};
      `FCC_A_IRQ_STAT: rd_mux = {28'h0, irq_stat_q};
      `FCC_A_IRQ_MASK: rd_mux = {28'h0, irq_mask_q};
      `FCC_A_CARRIAGE: rd_mux = {24'h0, carr_q};
      `FCC_A_SENSE_LO: rd_mux = sense_q[31:0];
      `FCC_A_SENSE_HI: rd_mux = {16'h0, sense_q[47:32]};
      `FCC_A_LINE_CFG: rd_mux = {16'h0, line_positions, index_q};
      default: rd_mux = 32'h0;
    endcase
  end
// ****************************************************************
// Interrupt mask and motion hold
// ****************************************************************
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_mask_q <= {`FCC_EV_W{1'b0}};
      motion_hold_q <= 1'b0;
    end else if (clk_en) begin
      if (wr_mask) begin
        irq_mask_q <= avs_writedata[`FCC_EV_W-1:0];
      end
      // A parity fault freezes the carriage until software clears the hold.
      if (print_parity_err) begin
        motion_hold_q <= 1'b1;
      end else if (wr_ctrl && avs_writedata[0]) begin
        motion_hold_q <= 1'b0;
      end
    end
  end
// ****************************************************************
// Command engine and registers
// ****************************************************************
  always @* begin
    ev_set = {`FCC_EV_W{1'b0}};
    ev_set[`FCC_EV_PARITY] = clk_en && print_parity_err;
  end
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      carr_q <= {ADDR_W{1'b0}};
      ld_ptr_q <= {ADDR_W{1'b0}};
      remain_q <= {ADDR_W{1'b0}};
      want_ch_q <= 4'h0;
      skip_q <= 1'b0;
      line1_seen_q <= 2'h0;
      ld_end_seen_q <= 1'b0;
      ld_bad_q <= 1'b0;
      index_q <= 8'h00;
      lpi8_q <= 1'b0;
      irq_stat_q <= {`FCC_EV_W{1'b0}};
      sense_q <= 48'h0;
      form_step <= 1'b0;
    end else if (clk_en) begin
      form_step <= 1'b0;
      irq_stat_q <= fcc_w1c(irq_stat_q, irq_clr, ev_set);
      // The fault is logged at once; software clears sense and hold with one write.
      if (print_parity_err) begin
        sense_q[`FCC_SNS_PARITY] <= 1'b1;
      end else if (wr_ctrl && avs_writedata[0]) begin
        sense_q <= 48'h0;
      end
      case (state_q)
        ST_IDLE: begin
          if (wr_cmd && cmd_op == `FCC_CMD_LOAD) begin
            state_q <= ST_LOAD;
            ld_ptr_q <= {ADDR_W{1'b0}};
            ld_end_seen_q <= 1'b0;
            ld_bad_q <= 1'b0;
          end else if (wr_cmd && !motion_hold_q && !print_parity_err &&
                       (cmd_op == `FCC_CMD_SPACE || cmd_op == `FCC_CMD_SKIP)) begin
            state_q <= ST_MOVE;
            skip_q <= (cmd_op == `FCC_CMD_SKIP);
            want_ch_q <= cmd_arg[3:0];
            remain_q <= cmd_arg[ADDR_W-1:0];
            line1_seen_q <= 2'h0;
          end
        end
        ST_MOVE: begin
          if (motion_hold_q || print_parity_err) begin
            state_q <= ST_IDLE;
          end else begin
            form_step <= 1'b1;
            carr_q <= next_addr;
            if (!skip_q) begin
              remain_q <= remain_q - 1'b1;
              if (remain_q <= 1) begin
                state_q <= ST_IDLE;
                irq_stat_q[`FCC_EV_DONE] <= 1'b1;
              end
            end else if (fcb_mem[next_addr][`FCC_ENT_CH_MSB:0] == want_ch_q) begin
              state_q <= ST_IDLE;
              irq_stat_q[`FCC_EV_DONE] <= 1'b1;
            end else if (next_addr == 0) begin
              line1_seen_q <= line1_seen_q + 1'b1;
              if (line1_seen_q == 2'h1) begin
                state_q <= ST_IDLE;
                irq_stat_q[`FCC_EV_RUNAWAY] <= 1'b1;
                sense_q[`FCC_SNS_RUNAWAY] <= 1'b1;
              end
            end
          end
        end
        ST_LOAD: begin
          if (wr_data && ld_room) begin
            ld_ptr_q <= ld_ptr_q + 1'b1;
            if (ld_ptr_q == 0) begin
              // An offset beyond the limit is refused, so the old offset stays in force.
              if (avs_writedata[7:0] > `FCC_INDEX_MAX) begin
                ld_bad_q <= 1'b1;
                sense_q[`FCC_SNS_BAD_INDEX] <= 1'b1;
              end else begin
                index_q <= avs_writedata[7:0];
              end
            end else begin
              if (ld_ptr_q == 1) begin
                lpi8_q <= avs_writedata[`FCC_ENT_LPI8_BIT];
              end
              if (!fcc_ch_ok(avs_writedata[`FCC_ENT_CH_MSB:0])) begin
                ld_bad_q <= 1'b1;
              end
              if (avs_writedata[`FCC_ENT_END_BIT]) begin
                ld_end_seen_q <= 1'b1;
              end
            end
          end else if (wr_cmd || ld_ptr_q == LINES + 1) begin
            // Loading closes on any command write or when every entry is filled.
            state_q <= ST_IDLE;
            carr_q <= {ADDR_W{1'b0}};
            if (ld_bad_q || !ld_end_seen_q) begin
              irq_stat_q[`FCC_EV_LOAD_ERR] <= 1'b1;
              sense_q[`FCC_SNS_LOAD_ERR] <= 1'b1;
            end else begin
              irq_stat_q[`FCC_EV_DONE] <= 1'b1;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule // fcc_carriage

// ===== rtl/fcc_regs.vh
// Register map, field layout and constants of the forms control carriage block.
`ifndef FCC_REGS_VH
`define FCC_REGS_VH
// ****************************************************************
// Register word addresses (byte address divided by four)
// ****************************************************************
`define FCC_A_CTRL 4'h0
`define FCC_A_CMD 4'h1
`define FCC_A_STATUS 4'h2
`define FCC_A_IRQ_STAT 4'h3
`define FCC_A_IRQ_MASK 4'h4
`define FCC_A_LOAD_DATA 4'h5
`define FCC_A_CARRIAGE 4'h6
`define FCC_A_SENSE_LO 4'h7
`define FCC_A_SENSE_HI 4'h8
`define FCC_A_LINE_CFG 4'h9
// ****************************************************************
// Command codes and fields
// ****************************************************************
`define FCC_CMD_SPACE 2'h1
`define FCC_CMD_SKIP 2'h2
`define FCC_CMD_LOAD 2'h3
`define FCC_CMD_OP_LSB 0
`define FCC_CMD_OP_MSB 1
`define FCC_CMD_ARG_LSB 8
`define FCC_CMD_ARG_MSB 15
// ****************************************************************
// Buffer entry layout: channel code, end flag, density flag
// ****************************************************************
`define FCC_ENT_CH_MSB 3
`define FCC_ENT_END_BIT 4
`define FCC_ENT_LPI8_BIT 5
`define FCC_CH_MAX 4'hC
`define FCC_INDEX_MAX 8'h1E
`define FCC_POS_STD 8'h84
`define FCC_POS_WIDE 8'h96
// ****************************************************************
// Interrupt and sense bits
// ****************************************************************
`define FCC_EV_DONE 0
`define FCC_EV_LOAD_ERR 1
`define FCC_EV_RUNAWAY 2
`define FCC_EV_PARITY 3
`define FCC_EV_W 4
`define FCC_SNS_LOAD_ERR 0
`define FCC_SNS_RUNAWAY 1
`define FCC_SNS_PARITY 2
`define FCC_SNS_BAD_INDEX 3
`endif

// ===== verification/fcc_carriage_properties.sv
// Checker of the forms control carriage port behaviour.
`timescale 1ns/1ps
module fcc_carriage_checker #(
  parameter LINES = 180,
  parameter WIDE_LINE = 0
) (
  // Clock and reset.
  input wire core_clk,
  input wire reset_n,
  // Register bus.
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // Printer side.
  input wire print_parity_err,
  input wire form_step,
  input wire [7:0] print_offset,
  input wire [7:0] line_positions,
  input wire irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire req = avs_read | avs_write;
  wire rd_ack = avs_read & ~avs_waitrequest;
  property p_wait_first; $rose(req) |-> avs_waitrequest; endproperty
  a_wait_first: assert property (p_wait_first)
    else $error("new request not held off");
  property p_ack_next; $rose(req) |=> !avs_waitrequest; endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("request not answered next cycle");
  property p_idle; !req |-> !avs_waitrequest; endproperty
  a_idle: assert property (p_idle)
    else $error("wait raised while idle");
  property p_line_pos; line_positions == (WIDE_LINE ? 8'h96 : 8'h84); endproperty
  a_line_pos: assert property (p_line_pos)
    else $error("wrong print line width");
  property p_offset; print_offset <= 8'h1E; endproperty
  a_offset: assert property (p_offset)
    else $error("offset beyond limit");
  // Motion must stay stopped long enough for the host to see the fault.
  property p_parity; $rose(print_parity_err) |-> ##2 !form_step [*4]; endproperty
  a_parity: assert property (p_parity)
    else $error("form moved after parity fault");
  property p_carriage; rd_ack && avs_address == 4'h6 |-> avs_readdata < LINES; endproperty
  a_carriage: assert property (p_carriage)
    else $error("carriage beyond buffer");
  property p_sense; rd_ack && avs_address == 4'h8 |-> avs_readdata[31:16] == 16'h0; endproperty
  a_sense: assert property (p_sense)
    else $error("sense wider than six bytes");
  c_step: cover property (form_step);
  c_irq: cover property ($rose(irq));
  c_parity: cover property ($rose(print_parity_err));
endmodule // fcc_carriage_checker

// ===== verification/fcc_host.sv
// Host channel model issuing printer commands over the register bus.
`timescale 1ns/1ps
module fcc_host (
  // Clock.
  input wire core_clk,
  // Bus master.
  output logic [3:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest
);
  initial begin
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
  end
  // Released lines show inverted data so stale values cannot pass for good ones.
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~a;
    avs_writedata <= ~d;
  endtask
endmodule // fcc_host

// ===== verification/test_forms_control_carriage_logic.sv
// Self-checking bench of the forms control carriage block.
`timescale 1ns/1ps
`include "fcc_regs.vh"
module test_forms_control_carriage_logic;
  logic core_clk, reset_n, print_parity_err;
  wire [3:0] avs_address;
  wire avs_read, avs_write, avs_waitrequest, form_step, lpi8_mode, irq;
  wire [31:0] avs_writedata, avs_readdata;
  wire [7:0] print_offset, line_positions;
  int fail_count, comparisons, steps, end_line;
  logic [31:0] q;
  logic [7:0] idx, n;
  logic lpi;
  logic [3:0] chan [0:179];
  fcc_host host (.core_clk(core_clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  fcc_carriage dut (.core_clk(core_clk), .clk_en(1'b1), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .print_parity_err(print_parity_err),
    .form_step(form_step), .lpi8_mode(lpi8_mode), .print_offset(print_offset),
    .line_positions(line_positions), .irq(irq));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (form_step === 1'b1) steps <= steps + 1;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask
  // Polls at most 400 times; a hang then shows up as a counted failure with its own message.
  task automatic wait_event(input int b);
    int k;
    k = 0;
    do begin
      host.xfer(1'b0, `FCC_A_IRQ_STAT, 32'h0, q);
      k++;
    end while (q[b] !== 1'b1 && k < 400);
    if (q[b] !== 1'b1) begin
      fail_count++;
      $display("unexpected at %0t: event %0d never set", $time, b);
    end
  endtask
  task automatic load();
    wr(`FCC_A_CMD, 32'h3);
    wr(`FCC_A_LOAD_DATA, {24'h0, idx});
    for (int i = 0; i < 180; i++)
      wr(`FCC_A_LOAD_DATA, {26'h0, lpi && i == 0, i == end_line, chan[i]});
  endtask
  // A load that must be refused: the error event fires and sense shows why.
  task automatic bad_load(input logic [31:0] sense_exp);
    wr(`FCC_A_CTRL, 32'h1);
    wr(`FCC_A_IRQ_STAT, 32'hF);
    load();
    wait_event(`FCC_EV_LOAD_ERR);
    rd(`FCC_A_SENSE_LO, sense_exp);
  endtask
  function automatic int skip_steps(input int start, input logic [3:0] ch);
    int a, seen, k;
    a = start;
    seen = 0;
    k = 0;
    do begin
      a = (a == end_line) ? 0 : a + 1;
      k++;
      seen += (a == 0);
    end while (chan[a] != ch && seen < 2);
    return k;
  endfunction
  task automatic end_of_test;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge core_clk);
    fail_count++;
    end_of_test;
  end
  initial begin
    {fail_count, comparisons, steps} = 0;
    reset_n = 1'b0;
    print_parity_err = 1'b0;
    q = $urandom(32'hF83B);
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(`FCC_A_SENSE_LO, 32'h0);
    rd(`FCC_A_SENSE_HI, 32'h0);
    check(line_positions, 32'h84);
    rd(`FCC_A_LINE_CFG, 32'h8400);
    end_line = 20 + $urandom % 40;
    foreach (chan[i]) chan[i] = 1 + $urandom % 4;
    chan[9] = 4'h7;
    idx = $urandom % 31;
    lpi = 1'b1;
    wr(`FCC_A_IRQ_MASK, 32'hF);
    load();
    wait_event(`FCC_EV_DONE);
    rd(`FCC_A_IRQ_STAT, 32'h1);
    check(lpi8_mode, 32'h1);
    check(print_offset, idx);
    rd(`FCC_A_LINE_CFG, {16'h0, 8'h84, idx});
    check(irq, 32'h1);
    wr(`FCC_A_IRQ_STAT, 32'hF);
    @(negedge core_clk);
    check(irq, 32'h0);
    n = 1 + $urandom % 5;
    steps = 0;
    wr(`FCC_A_CMD, {16'h0, n, 8'h01});
    wait_event(`FCC_EV_DONE);
    check(steps, n);
    rd(`FCC_A_CARRIAGE, n);
    wr(`FCC_A_IRQ_STAT, 32'hF);
    steps = 0;
    wr(`FCC_A_CMD, 32'h0702);
    wait_event(`FCC_EV_DONE);
    check(steps, skip_steps(n, 7));
    rd(`FCC_A_CARRIAGE, 32'h9);
    wr(`FCC_A_IRQ_STAT, 32'hF);
    steps = 0;
    wr(`FCC_A_CMD, 32'h0C02);
    wait_event(`FCC_EV_RUNAWAY);
    check(steps, skip_steps(9, 12));
    rd(`FCC_A_CARRIAGE, 32'h0);
    rd(`FCC_A_SENSE_LO, 32'h2);
    wr(`FCC_A_CTRL, 32'h1);
    wr(`FCC_A_IRQ_STAT, 32'hF);
    print_parity_err <= 1'b1;
    @(posedge core_clk);
    print_parity_err <= 1'b0;
    steps = 0;
    wr(`FCC_A_CMD, 32'h0201);
    repeat (10) @(posedge core_clk);
    check(steps, 0);
    rd(`FCC_A_SENSE_LO, 32'h4);
    rd(`FCC_A_IRQ_STAT, 32'h8);
    wr(`FCC_A_IRQ_MASK, 32'h0);
    @(negedge core_clk);
    check(irq, 32'h0);
    n = idx;
    lpi = 1'b0;
    chan[0] = 4'hD;
    bad_load(32'h1);
    check(lpi8_mode, 32'h0);
    chan[0] = 4'h1;
    end_line = 255;
    bad_load(32'h1);
    end_line = 30;
    idx = 8'h1F;
    bad_load(32'h9);
    check(print_offset, n);
    rd(4'hF, 32'h0);
    end_of_test;
  end
endmodule // test_forms_control_carriage_logic
bind fcc_carriage fcc_carriage_checker #(.LINES(LINES), .WIDE_LINE(WIDE_LINE)) chk (
  .core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .print_parity_err(print_parity_err), .form_step(form_step), .print_offset(print_offset),
  .line_positions(line_positions), .irq(irq));
